// file: src/adcsc_consts.svh
// adcsc_consts.svh: named counts, positions and reset values for the
// serial conversion control block.
// assumes: included by bare name wherever a count or position is needed.
`ifndef ADCSC_CONSTS_SVH
`define ADCSC_CONSTS_SVH

// falling-edge counter
`define ADCSC_CNT_W 5
`define ADCSC_CNT_ZERO 5'h00
`define ADCSC_CNT_ONE 5'h01

// conversion length and track-return point per resolution
`define ADCSC_CONV_12 5'h0e
`define ADCSC_TRACK_12 5'h0d
`define ADCSC_CONV_10 5'h0c
`define ADCSC_TRACK_10 5'h0b
`define ADCSC_CONV_8 5'h0a
`define ADCSC_TRACK_8 5'h09

// frame positions
`define ADCSC_LAST_SHIFT 5'h0f
`define ADCSC_FRAME_LEN 5'h10
`define ADCSC_TRAIL_12 5'h0e
`define ADCSC_TRAIL_10 5'h0c
`define ADCSC_TRAIL_8 5'h0a

// lowest result bit kept for the shorter resolutions
`define ADCSC_LSB_10 2
`define ADCSC_LSB_8 4

// power window on the falling-edge count
`define ADCSC_PD_MIN 5'h02
`define ADCSC_PD_MAX 5'h0a

// widths and reset values
`define ADCSC_RES_W 12
`define ADCSC_FRAME_W 16
`define ADCSC_FRAME_MSB 15
`define ADCSC_FRAME_RST 16'h0000
`define ADCSC_LEAD_ZEROS 2'h0
`define ADCSC_TAIL_ZEROS 2'h0
`define ADCSC_PAD2 2'h0
`define ADCSC_PAD4 4'h0
`define ADCSC_CS_IDLE 1'b1
`define ADCSC_SCLK_IDLE 1'b1

`endif

// file: src/adcsc_ctrl.sv
// adcsc_ctrl: chip-select and serial-clock sequencing of a 12/10/8-bit
// successive-approximation converter: sampling, bit shifting, abort and
// power-down entry and exit.
// assumes: cs_n and sclk arrive from pins; conv_data_i and res_sel_i come
// from logic on clk_i and hold steady while a frame is running.
`timescale 1ns/10ps
`include "adcsc_consts.svh"
module adcsc_ctrl
   import adcsc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   output logic serial_result_out_o,
   output logic serial_result_oe_o,
   // converter core
   input wire logic [`ADCSC_RES_W-1:0] conv_data_i,
   input wire logic [1:0] res_sel_i,
   output logic sample_o,
   output logic hold_o,
   output logic conv_busy_o,
   output logic powered_o
);
   // synchronised pin events
   logic cs_level_w;
   logic cs_rise_w;
   logic cs_fall_w;
   logic sclk_level_w;
   logic sclk_rise_w;
   logic sclk_fall_w;

   // state
   adcsc_state_t state_reg;
   adcsc_state_t state_next;
   adcsc_res_t res_reg;
   adcsc_res_t res_next;
   logic [`ADCSC_CNT_W-1:0] cnt_reg;
   logic [`ADCSC_CNT_W-1:0] cnt_next;
   logic oe_reg;
   logic oe_next;
   logic hold_reg;
   logic hold_next;
   logic busy_reg;
   logic busy_next;
   logic powered_reg;
   logic powered_next;
   logic sample_reg;

   // decode
   logic active_w;
   logic edge_w;
   logic [`ADCSC_CNT_W-1:0] cnt_inc_w;
   logic [`ADCSC_CNT_W-1:0] conv_len_w;
   logic [`ADCSC_CNT_W-1:0] track_cnt_w;
   logic [`ADCSC_CNT_W-1:0] trail_w;
   logic rise_keep_w;
   logic rise_down_w;
   logic rise_up_w;
   logic conv_end_w;
   logic frame_end_w;
   logic track_back_w;
   logic wake_track_w;
   logic shift_w;
   logic [`ADCSC_RES_W-1:0] masked_w;
   logic [`ADCSC_FRAME_W-1:0] frame_w;
   logic sdo_w;

   adcsc_sync #(
      .INIT(`ADCSC_CS_IDLE)
   ) u_cs_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i(cs_n_i),
      .level_o(cs_level_w),
      .rise_o(cs_rise_w),
      .fall_o(cs_fall_w)
   );

   adcsc_sync #(
      .INIT(`ADCSC_SCLK_IDLE)
   ) u_sclk_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .async_i(sclk_i),
      .level_o(sclk_level_w),
      .rise_o(sclk_rise_w),
      .fall_o(sclk_fall_w)
   );

   // a select edge wins over a clock edge in the same cycle
   assign active_w = (state_reg == ADCSC_SHIFT);
   assign edge_w = active_w & sclk_fall_w & ~cs_rise_w & ~cs_fall_w;
   assign cnt_inc_w = cnt_reg + `ADCSC_CNT_ONE;

   assign conv_len_w = (res_reg == ADCSC_RES8) ? `ADCSC_CONV_8 :
                       (res_reg == ADCSC_RES10) ? `ADCSC_CONV_10 :
                       `ADCSC_CONV_12;
   assign track_cnt_w = (res_reg == ADCSC_RES8) ? `ADCSC_TRACK_8 :
                        (res_reg == ADCSC_RES10) ? `ADCSC_TRACK_10 :
                        `ADCSC_TRACK_12;
   assign trail_w = (res_reg == ADCSC_RES8) ? `ADCSC_TRAIL_8 :
                    (res_reg == ADCSC_RES10) ? `ADCSC_TRAIL_10 :
                    `ADCSC_TRAIL_12;

   // power decision on a select rise, by falling-edge count
   assign rise_keep_w = cnt_reg < `ADCSC_PD_MIN;
   assign rise_up_w = cnt_reg >= `ADCSC_PD_MAX;
   assign rise_down_w = ~rise_keep_w & ~rise_up_w;

   assign conv_end_w = edge_w & (cnt_inc_w == conv_len_w);
   assign frame_end_w = edge_w & (cnt_reg == `ADCSC_LAST_SHIFT);
   // rising edge after the last sampling fall puts the hold back to track
   assign track_back_w = active_w & sclk_rise_w & ~cs_rise_w &
                         (cnt_reg >= track_cnt_w);
   // waking from power-down: track on the first clock edge of the frame
   assign wake_track_w = active_w & ~powered_reg & ~cs_rise_w &
                         (sclk_rise_w | sclk_fall_w);
   // nothing shifts on the 16th fall: that edge releases the line and powers the device up
   assign shift_w = edge_w & (cnt_reg < `ADCSC_LAST_SHIFT);

   // result left-justified; unused low bits forced to zero per resolution
   // eight result bits for the 8-bit variant, then four padding zeros
   assign masked_w = (res_sel_i == ADCSC_RES8) ?
                     {conv_data_i[`ADCSC_RES_W-1:`ADCSC_LSB_8],
                      `ADCSC_PAD4} :
                     (res_sel_i == ADCSC_RES10) ?
                     {conv_data_i[`ADCSC_RES_W-1:`ADCSC_LSB_10],
                      `ADCSC_PAD2} :
                     conv_data_i;
   assign frame_w = {`ADCSC_LEAD_ZEROS, masked_w, `ADCSC_TAIL_ZEROS};

   assign cnt_next = cs_fall_w ? `ADCSC_CNT_ZERO :
                     edge_w ? cnt_inc_w : cnt_reg;

   assign state_next = cs_fall_w ? ADCSC_SHIFT :
                       cs_rise_w ? ADCSC_IDLE :
                       frame_end_w ? ADCSC_DONE : state_reg;

   assign res_next = cs_fall_w ? adcsc_res_t'(res_sel_i) : res_reg;

   // any select rise floats the line: abort, or end of a short frame
   assign oe_next = cs_fall_w ? 1'b1 :
                    cs_rise_w ? 1'b0 :
                    frame_end_w ? 1'b0 : oe_reg;

   // on power-down entry the hold stays held
   assign hold_next = cs_fall_w ? 1'b1 :
                      (cs_rise_w & active_w) ?
                      (rise_down_w | (~powered_reg & ~rise_up_w)) :
                      (track_back_w | wake_track_w) ? 1'b0 : hold_reg;

   assign busy_next = cs_fall_w ? 1'b1 :
                      cs_rise_w ? 1'b0 :
                      conv_end_w ? 1'b0 : busy_reg;

   assign powered_next = (cs_rise_w & active_w) ?
                         (rise_up_w | (rise_keep_w & powered_reg)) :
                         (edge_w & (cnt_inc_w == `ADCSC_FRAME_LEN)) ? 1'b1 :
                         powered_reg;

   adcsc_shifter u_shifter (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .load_i(cs_fall_w),
      .shift_i(shift_w),
      .frame_i(frame_w),
      .bit_o(sdo_w)
   );

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_reg <= ADCSC_IDLE;
         res_reg <= ADCSC_RES12;
         cnt_reg <= `ADCSC_CNT_ZERO;
         oe_reg <= 1'b0;
         hold_reg <= 1'b0;
         busy_reg <= 1'b0;
         powered_reg <= 1'b1;
         sample_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         res_reg <= res_next;
         cnt_reg <= cnt_next;
         oe_reg <= oe_next;
         hold_reg <= hold_next;
         busy_reg <= busy_next;
         powered_reg <= powered_next;
         sample_reg <= cs_fall_w;
      end
   end

   assign serial_result_out_o = sdo_w;
   assign serial_result_oe_o = oe_reg;
   assign sample_o = sample_reg;
   assign hold_o = hold_reg;
   assign conv_busy_o = busy_reg;
   assign powered_o = powered_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   start_frame_a:
      assert property (cs_fall_w |=> oe_reg && hold_reg && busy_reg &&
                       sample_reg)
      else $error("select fall did not start frame");

   first_zero_a:
      assert property (cs_fall_w |=> !sdo_w && cnt_reg == `ADCSC_CNT_ZERO)
      else $error("frame did not open with zero at count zero");

   count_step_a:
      assert property (edge_w |=> cnt_reg == $past(cnt_reg) + `ADCSC_CNT_ONE)
      else $error("falling edge not counted");

   track_12_a:
      assert property (track_back_w && res_reg == ADCSC_RES12 |->
                       cnt_reg >= `ADCSC_TRACK_12 ##1 !hold_reg)
      else $error("12-bit hold did not return to track");

   track_10_a:
      assert property (active_w && res_reg == ADCSC_RES10 && sclk_rise_w &&
                       !cs_rise_w && cnt_reg == `ADCSC_TRACK_10 |=> !hold_reg)
      else $error("10-bit hold did not return to track");

   track_8_a:
      assert property (active_w && res_reg == ADCSC_RES8 && sclk_rise_w &&
                       !cs_rise_w && cnt_reg == `ADCSC_TRACK_8 |=> !hold_reg)
      else $error("8-bit hold did not return to track");

   abort_12_a:
      assert property (active_w && cs_rise_w && res_reg == ADCSC_RES12 &&
                       cnt_reg < `ADCSC_CONV_12 |=> !oe_reg && !busy_reg)
      else $error("12-bit abort left output driven");

   abort_10_a:
      assert property (active_w && cs_rise_w && res_reg == ADCSC_RES10 &&
                       cnt_reg < `ADCSC_CONV_10 |=> !oe_reg && !busy_reg)
      else $error("10-bit abort left output driven");

   trail_zero_a:
      assert property (active_w && cnt_reg >= trail_w |-> !sdo_w)
      else $error("trailing bit not zero");

   release_16_a:
      assert property (frame_end_w |=> !oe_reg ##1 !oe_reg)
      else $error("output not released on 16th fall");

   short_frame_a:
      assert property ($rose(cs_level_w) |=> !oe_reg [*2])
      else $error("output driven after select rise");

   power_down_a:
      assert property (active_w && cs_rise_w && cnt_reg >= `ADCSC_PD_MIN &&
                       cnt_reg < `ADCSC_PD_MAX |=> !powered_reg && hold_reg)
      else $error("power-down not entered");

   keep_normal_a:
      assert property (active_w && cs_rise_w && powered_reg &&
                       cnt_reg < `ADCSC_PD_MIN |=> powered_reg)
      else $error("early select rise powered down");

   wake_gate_a:
      assert property (active_w && cs_rise_w && !powered_reg &&
                       cnt_reg < `ADCSC_PD_MAX |=> !powered_reg)
      else $error("early select rise woke the device");

   conv_done_a:
      assert property (conv_end_w |=> !busy_reg && cnt_reg == conv_len_w)
      else $error("conversion end not at its clock count");

   sclk_quiet_a:
      assert property (!active_w && !cs_fall_w |=> cnt_reg == $past(cnt_reg))
      else $error("count moved outside a frame");

   dummy_wake_a:
      assert property (edge_w && cnt_reg == `ADCSC_LAST_SHIFT |=>
                       powered_reg && !oe_reg)
      else $error("16th fall did not power up and release");

   wake_track_a:
      assert property (wake_track_w |=> !hold_reg)
      else $error("waking frame did not return to track");

endmodule

// file: src/adcsc_pkg.sv
// adcsc_pkg: state and resolution types of the serial conversion control.
// assumes: nothing beyond the consts header for its users.
package adcsc_pkg;

   // gray along idle -> shifting -> released
   typedef enum logic [1:0] {
      ADCSC_IDLE  = 2'h0,
      ADCSC_SHIFT = 2'h1,
      ADCSC_DONE  = 2'h3
   } adcsc_state_t;

   typedef enum logic [1:0] {
      ADCSC_RES12 = 2'h0,
      ADCSC_RES10 = 2'h1,
      ADCSC_RES8  = 2'h2
   } adcsc_res_t;

endpackage

// file: src/adcsc_shifter.sv
// adcsc_shifter: 16-position output frame, msb first.
// assumes: load and shift come from the controller on the same clock.
`timescale 1ns/10ps
`include "adcsc_consts.svh"
module adcsc_shifter (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // control
   input wire logic load_i,
   input wire logic shift_i,
   input wire logic [`ADCSC_FRAME_W-1:0] frame_i,
   // serial bit, straight from the frame register
   output logic bit_o
);
   logic [`ADCSC_FRAME_W-1:0] frame_reg;
   logic [`ADCSC_FRAME_W-1:0] frame_next;

   // zeros enter from the bottom so trailing positions read low
   assign frame_next = load_i ? frame_i :
                       shift_i ? {frame_reg[`ADCSC_FRAME_W-2:0], 1'b0} :
                       frame_reg;
   assign bit_o = frame_reg[`ADCSC_FRAME_MSB];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         frame_reg <= `ADCSC_FRAME_RST;
      end else begin
         frame_reg <= frame_next;
      end
   end
endmodule

// file: src/adcsc_sync.sv
// adcsc_sync: three-flop synchroniser for a pin, with agreement filter
// and one-cycle edge pulses.
// assumes: async_i is outside the clk_i domain; INIT is the pin idle level.
`timescale 1ns/10ps
module adcsc_sync #(
   parameter logic INIT = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pin side
   input wire logic async_i,
   // filtered level and edges
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);
   logic ff1_reg;
   logic ff2_reg;
   logic ff3_reg;
   logic agree_w;

   // ff1 is read by ff2 only; the filter looks at ff2 and ff3
   assign agree_w = (ff2_reg == ff3_reg);

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ff1_reg <= INIT;
         ff2_reg <= INIT;
         ff3_reg <= INIT;
         level_o <= INIT;
         rise_o <= 1'b0;
         fall_o <= 1'b0;
      end else begin
         ff1_reg <= async_i;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         if (agree_w) begin
            level_o <= ff3_reg;
         end
         rise_o <= agree_w & ff3_reg & ~level_o;
         fall_o <= agree_w & ~ff3_reg & level_o;
      end
   end
endmodule

// file: verification/adcsc_ctrl_bench.sv
// adcsc_ctrl_bench: frames of every resolution, 16- and 14-clock frames and
// eight aborts and a 16-clock dummy frame, compared with a behavioural model of the serial output.
// assumes: adcsc_host sits on the pins; core inputs held during frames.
`timescale 1ns/10ps
`include "adcsc_consts.svh"
`define ACHK(nm, e, g) begin \
   n_tests++; \
   if ((g) !== (e)) begin \
      bad_count++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
   end \
end
module adcsc_ctrl_bench;
   import adcsc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, sclk, sdo, oe, sample, hold, busy, powered;
   logic [`ADCSC_RES_W-1:0] conv_data = 12'h000;
   logic [1:0] res_sel = 2'h0;
   logic [31:0] seed = 32'hedd6_3133;
   logic pwr = 1'b1;
   int n_tests = 0;
   int bad_count = 0;
   int n_samp = 0;
   int ab_n [9] = '{1, 5, 9, 12, 2, 16, 9, 10, 0};
   logic [1:0] ab_r [9] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2,
                            2'h2, 2'h3};

   always #2 clk = ~clk;
   // counted on the falling clk edge, half a cycle after launch, so the pulse is settled when read
   always @(negedge clk) if (sample === 1'b1) n_samp++;

   adcsc_ctrl adcsc_ctrl_i (.clk_i(clk), .rst_n_i(rst_n), .cs_n_i(cs_n),
      .sclk_i(sclk), .serial_result_out_o(sdo), .serial_result_oe_o(oe),
      .conv_data_i(conv_data), .res_sel_i(res_sel), .sample_o(sample),
      .hold_o(hold), .conv_busy_o(busy), .powered_o(powered));

   adcsc_host adcsc_host_i (.clk_i(clk), .cs_n_o(cs_n), .sclk_o(sclk),
      .data_i(sdo), .oe_i(oe), .hold_i(hold), .busy_i(busy),
      .powered_i(powered));

   function automatic logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction

   task automatic run(input int n, input logic [11:0] d,
                      input logic [1:0] r);
      int w, k, p;
      logic sp, e, eh, eb;
      w = (r == 2'h1) ? 10 : (r == 2'h2) ? 8 : 12;
      sp = pwr;
      p = n_samp;
      conv_data = d;
      res_sel = r;
      adcsc_host_i.frame(n);
      for (k = 0; k <= n; k++) begin
         e = (k >= 2 && k < 2 + w) ? d[13 - k] : 1'b0;
         // a powered-down frame goes to track at its first sclk edge
         eh = (k == 0) ? 1'b1 : (sp && k < w + 1);
         eb = (k < w + 2);
         if (k < 16) begin
            `ACHK("data", e, adcsc_host_i.bit_q[k])
            `ACHK("oe", 1'b1, adcsc_host_i.oe_q[k])
         end else begin
            `ACHK("oe at 16", 1'b0, adcsc_host_i.oe_q[k])
         end
         `ACHK("hold", eh, adcsc_host_i.hold_q[k])
         if (sp) begin
            `ACHK("busy", eb, adcsc_host_i.busy_q[k])
         end
      end
      if (n >= 10) pwr = 1'b1;
      else if (n >= 2) pwr = 1'b0;
      `ACHK("oe after", 1'b0, adcsc_host_i.oe_q[17])
      `ACHK("busy after", 1'b0, adcsc_host_i.busy_q[17])
      `ACHK("powered", pwr, adcsc_host_i.powered_q)
      `ACHK("hold after", ~pwr, adcsc_host_i.hold_q[17])
      `ACHK("samples", p + 1, n_samp)
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      bad_count++;
      summarize();
   end

   initial begin
      int i;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      `ACHK("powered at reset", 1'b1, powered)
      `ACHK("oe at reset", 1'b0, oe)
      // every resolution code, full 16-clock frames
      for (i = 0; i < 4; i++) begin
         seed = xs(seed);
         run(16, seed[11:0], 2'(i));
      end
      // random data and resolution, 14- and 16-clock frames back to back
      for (i = 0; i < 6; i++) begin
         seed = xs(seed);
         run((i % 2) ? 14 : 16, seed[11:0], seed[13:12]);
      end
      // aborts across the power window, entry and dummy-frame exit
      for (i = 0; i < 9; i++) begin
         seed = xs(seed);
         run(ab_n[i], seed[11:0], ab_r[i]);
      end
      summarize();
   end
endmodule

// file: verification/adcsc_host.sv
// adcsc_host: behavioural serial host that runs one select frame of a
// chosen number of falling serial clock edges and captures the pins.
// assumes: driven on falling clk_i edges; the bench reads the captures.
`timescale 1ns/10ps
module adcsc_host (
   // clock
   input wire logic clk_i,
   // device pins
   output logic cs_n_o,
   output logic sclk_o,
   input wire logic data_i,
   input wire logic oe_i,
   // device status: hold and busy at each capture, powered after the last
   input wire logic hold_i,
   input wire logic busy_i,
   input wire logic powered_i
);
   // each sclk phase is 8 clk cycles, well above the 3-cycle filter
   localparam int HALF = 8;
   // 16 cycles of 4 ns keep the acquisition interval above 50 ns
   localparam int QUIET = 16;
   // captures 0..16 follow each fall; 17 is taken after select rises
   logic bit_q [0:17];
   logic oe_q [0:17];
   logic hold_q [0:17];
   logic busy_q [0:17];
   logic powered_q;

   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b1;
   end

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic capture(input int k);
      bit_q[k] = data_i;
      oe_q[k] = oe_i;
      hold_q[k] = hold_i;
      busy_q[k] = busy_i;
   endtask

   task automatic frame(input int n);
      int k;
      cs_n_o = 1'b0;
      wait_n(HALF);
      capture(0);
      for (k = 1; k <= n; k++) begin
         sclk_o = 1'b0;
         wait_n(HALF);
         sclk_o = 1'b1;
         wait_n(HALF);
         // capture HALF cycles after the rise, the bit of the last fall
         capture(k);
      end
      // select rises with sclk high, after the chosen fall
      cs_n_o = 1'b1;
      wait_n(HALF);
      capture(17);
      powered_q = powered_i;
      // line released, host waits before next select fall
      wait_n(QUIET);
   endtask
endmodule
